// ===== design/ebc_consts.svh
// Constants for the external bus control block
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH

// Configuration bit positions
`define EBC_CFG_WIDTH_BIT    1
`define EBC_CFG2_WIDTH_BIT   2
`define EBC_CFG_WR_MODE_BIT  2
`define EBC_CFG_HI_MODE_BIT  3
`define EBC_CFG_VALID_BIT    4
`define EBC_CFG_WAIT_LSB     5
`define EBC_CFG_WAIT_MSB     7

// Non-maskable interrupt vector location
`define EBC_NMI_VECTOR       16'h203e

// Program memory window routed on chip when the select pin was high
`define EBC_INT_LO           24'hff2000
`define EBC_INT_HI           24'hff9fff

// Shared pin indices
`define EBC_PIN_CLK          0
`define EBC_PIN_STB          1
`define EBC_PIN_RD           2
`define EBC_PIN_WR_LO        3
`define EBC_PIN_WR_HI        4
`define EBC_PIN_FETCH        5
`define EBC_NPINS            6

// Pin reset levels: read and write strobes come up high, the rest low
`define EBC_PIN_RST          6'h1c

`endif

// ===== design/ebc_pkg.sv
// Types for the external bus control block
`default_nettype none
package ebc_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_strobe,
    st_check,
    st_end,
    st_hold
  } ebc_state_t;
endpackage
`default_nettype wire

// ===== design/ebc_pin_if.sv
// Shared pin values passed from the bus controller to the pin mux
`default_nettype none
interface ebc_pin_if;
  logic [5:0] bus_val;
  logic [5:0] func_en;
  logic [5:0] port_val;
  modport ctrl (output bus_val, output func_en, output port_val);
  modport mux  (input bus_val, input func_en, input port_val);
endinterface
`default_nettype wire

// ===== design/ebc_pin_mux.sv
// Registered mux between bus functions and port use of shared pins
`default_nettype none
`include "ebc_consts.svh"
module ebc_pin_mux (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Pin values
  ebc_pin_if.mux          pins,
  output logic [5:0]      pin_out
);
  // Reset levels of the shared pins, one bit each
  localparam logic [5:0] pin_rst_val = `EBC_PIN_RST;
  genvar i;
  generate
    for (i = 0; i < `EBC_NPINS; i++) begin : g_pin
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          pin_out[i] <= pin_rst_val[i];
        end else if (pins.func_en[i]) begin
          pin_out[i] <= pins.bus_val[i];
        end else begin
          pin_out[i] <= pins.port_val[i];
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_port_pass: assert property (!pins.func_en[`EBC_PIN_RD] |=>
    pin_out[`EBC_PIN_RD] == $past(pins.port_val[`EBC_PIN_RD]))
    else $error("port value not passed to idle pin");
endmodule
`default_nettype wire

// ===== design/ebc_bus_ctrl.sv
// External memory bus controller: strobes, width, hold, fetch flag, NMI
`default_nettype none
`include "ebc_consts.svh"
// Functional notes
// - Clock output is half rate, even duty
// - Both width bits set: pin picks width
// - Width pin low 8-bit, high 16-bit
// - Fixed 8 or 16 by width bits
// - NMI rising edge takes vector 203e
// - Fetch flag high on external fetch cycles
// - Fetch flag low for internal fetches
// - Select high: window goes on chip
// - Select low: window goes off chip
// - Access select captured at reset, held
// - Hold acknowledge shows bus released
// - Bus request while external cycle pending
// - Address strobe as latch or valid
// - Valid strobe goes high at cycle end
// - Address strobe only on external accesses
// - Read strobe only on external reads
// - Unused shared pins act as port pins
// - Ready low inserts bounded wait states
// - Write low on all or even writes
// - 16-bit lanes by A0 and high enable
module ebc_bus_ctrl (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Core request side
  input  wire logic        cpu_req_in,
  input  wire logic        cpu_write_in,
  input  wire logic        cpu_fetch_in,
  input  wire logic        cpu_word_in,
  input  wire logic [23:0] cpu_addr_in,
  input  wire logic [15:0] cpu_wdata_in,
  output logic [15:0]      cpu_rdata_out,
  output logic             cpu_done_out,
  output logic             cpu_int_sel_out,
  // Configuration
  input  wire logic [7:0]  chip_config_reg_in,
  input  wire logic [7:0]  chip_config_reg_second_in,
  input  wire logic [5:0]  port_func_en_in,
  input  wire logic [5:0]  port_data_in,
  // Bus input pins
  input  wire logic        bus_width_in,
  input  wire logic        ready_in,
  input  wire logic        nmi_in,
  input  wire logic        ext_access_select_in,
  input  wire logic        hold_in,
  input  wire logic [15:0] ad_in,
  // Bus output pins
  output logic [15:0]      ad_out,
  output logic             ad_oe_n_out,
  output logic [3:0]       addr_hi_out,
  output logic             clock_out,
  output logic             addr_strobe_out,
  output logic             read_n_out,
  output logic             write_low_n_out,
  output logic             write_high_n_out,
  output logic             fetch_indicator_out,
  output logic             bus_hold_ack_out,
  output logic             bus_pending_req_out,
  // Status
  output logic             nmi_take_out,
  output logic [15:0]      nmi_vector_out,
  output logic             ext_access_latched_out
);
  ebc_pkg::ebc_state_t state;
  logic        clk_div;
  logic        strap_lat;
  logic [23:0] cyc_addr;
  logic        cyc_write;
  logic        cyc_fetch;
  logic        cyc_word;
  logic        cyc_16;
  logic        second;
  logic [2:0]  wait_cnt;
  logic [15:0] wdata;
  logic        nmi_prev;
  logic [5:0]  pin_q;
  logic        accept;
  logic        acc_int;
  logic        acc_ext;
  logic        dyn_width;
  logic        start_16;
  logic [2:0]  wait_max;
  logic        check_last;
  logic        cont_second;
  logic        in_phase;
  logic        in_data;
  logic        lane_lo;
  logic        lane_hi;
  logic [5:0]  next_bus_val;

  ebc_pin_if pins ();

  function automatic logic is_internal(input logic [23:0] a, input logic sel);
    return sel && (a >= `EBC_INT_LO) && (a <= `EBC_INT_HI);
  endfunction

  assign wait_max    = chip_config_reg_in[`EBC_CFG_WAIT_MSB:`EBC_CFG_WAIT_LSB];
  assign dyn_width   = chip_config_reg_in[`EBC_CFG_WIDTH_BIT] &&
                       chip_config_reg_second_in[`EBC_CFG2_WIDTH_BIT];
  // Illegal all-zero setting falls to 8-bit, the safer width
  assign start_16    = dyn_width ? bus_width_in :
                       chip_config_reg_in[`EBC_CFG_WIDTH_BIT];
  // Done blocks a second take while the core drops its request
  assign accept      = (state == ebc_pkg::st_idle) && cpu_req_in && !cpu_done_out &&
                       !hold_in;
  assign acc_int     = accept && is_internal(cpu_addr_in, strap_lat);
  assign acc_ext     = accept && !is_internal(cpu_addr_in, strap_lat);
  assign check_last  = (state == ebc_pkg::st_check) && (ready_in || wait_cnt == wait_max);
  assign cont_second = !cyc_16 && cyc_word && !second;

  // Clock output divider
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      clk_div <= 1'b0;
    end else begin
      clk_div <= !clk_div;
    end
  end

  // Access select strap, caught while reset is held
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      strap_lat <= ext_access_select_in;
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state     <= ebc_pkg::st_idle;
      cyc_addr  <= 24'h000000;
      cyc_write <= 1'b0;
      cyc_fetch <= 1'b0;
      cyc_word  <= 1'b0;
      cyc_16    <= 1'b0;
      second    <= 1'b0;
      wait_cnt  <= 3'h0;
      wdata     <= 16'h0000;
    end else begin
      unique case (state)
        ebc_pkg::st_idle: begin
          if (hold_in) begin
            state <= ebc_pkg::st_hold;
          end else if (acc_ext) begin
            state     <= ebc_pkg::st_addr;
            cyc_addr  <= cpu_addr_in;
            cyc_write <= cpu_write_in;
            cyc_fetch <= cpu_fetch_in;
            cyc_word  <= cpu_word_in;
            cyc_16    <= start_16;
            second    <= 1'b0;
            wdata     <= cpu_wdata_in;
          end
        end
        ebc_pkg::st_addr: begin
          state    <= ebc_pkg::st_strobe;
          wait_cnt <= 3'h0;
        end
        ebc_pkg::st_strobe: begin
          state <= ebc_pkg::st_check;
        end
        ebc_pkg::st_check: begin
          if (check_last) begin
            state <= ebc_pkg::st_end;
          end else begin
            wait_cnt <= wait_cnt + 3'h1;
          end
        end
        ebc_pkg::st_end: begin
          // An 8-bit bus moves a word as two byte cycles, low byte first
          if (cont_second) begin
            second      <= 1'b1;
            cyc_addr[0] <= 1'b1;
            state       <= ebc_pkg::st_addr;
          end else begin
            state <= ebc_pkg::st_idle;
          end
        end
        ebc_pkg::st_hold: begin
          if (!hold_in) begin
            state <= ebc_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // Answer to the core
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cpu_done_out    <= 1'b0;
      cpu_int_sel_out <= 1'b0;
      cpu_rdata_out   <= 16'h0000;
    end else begin
      cpu_done_out    <= acc_int || (state == ebc_pkg::st_end && !cont_second);
      cpu_int_sel_out <= acc_int;
      if (accept) begin
        cpu_rdata_out <= 16'h0000;
      end else if (check_last && !cyc_write) begin
        if (!cyc_16) begin
          if (second) begin
            cpu_rdata_out[15:8] <= ad_in[7:0];
          end else begin
            cpu_rdata_out[7:0] <= ad_in[7:0];
          end
        end else if (cyc_word) begin
          cpu_rdata_out <= ad_in;
        end else if (cyc_addr[0]) begin
          cpu_rdata_out[7:0] <= ad_in[15:8];
        end else begin
          cpu_rdata_out[7:0] <= ad_in[7:0];
        end
      end
    end
  end

  // Shared pin functions, registered in the pin mux
  assign in_data = (state == ebc_pkg::st_strobe) || (state == ebc_pkg::st_check);
  assign in_phase = (state == ebc_pkg::st_addr) || in_data;
  assign lane_lo = !cyc_16 || !cyc_addr[0];
  assign lane_hi = cyc_16 && (cyc_word || cyc_addr[0]);

  always_comb begin
    next_bus_val = `EBC_PIN_RST;
    next_bus_val[`EBC_PIN_CLK] = clk_div;
    if (chip_config_reg_in[`EBC_CFG_VALID_BIT]) begin
      next_bus_val[`EBC_PIN_STB] = !in_phase;
    end else begin
      next_bus_val[`EBC_PIN_STB] = (state == ebc_pkg::st_addr);
    end
    next_bus_val[`EBC_PIN_RD] = !(in_data && !cyc_write);
    if (chip_config_reg_in[`EBC_CFG_WR_MODE_BIT]) begin
      next_bus_val[`EBC_PIN_WR_LO] = !(in_data && cyc_write && lane_lo);
    end else begin
      next_bus_val[`EBC_PIN_WR_LO] = !(in_data && cyc_write);
    end
    if (chip_config_reg_in[`EBC_CFG_HI_MODE_BIT]) begin
      next_bus_val[`EBC_PIN_WR_HI] = !(in_data && cyc_write && lane_hi);
    end else begin
      next_bus_val[`EBC_PIN_WR_HI] = !(in_phase && lane_hi);
    end
    next_bus_val[`EBC_PIN_FETCH] = cyc_fetch && !cyc_write &&
                                  (in_phase || state == ebc_pkg::st_end);
  end

  assign pins.bus_val  = next_bus_val;
  assign pins.func_en  = port_func_en_in;
  assign pins.port_val = port_data_in;

  ebc_pin_mux u_pin_mux (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .pins     (pins),
    .pin_out  (pin_q)
  );

  assign clock_out           = pin_q[`EBC_PIN_CLK];
  assign addr_strobe_out     = pin_q[`EBC_PIN_STB];
  assign read_n_out          = pin_q[`EBC_PIN_RD];
  assign write_low_n_out     = pin_q[`EBC_PIN_WR_LO];
  assign write_high_n_out    = pin_q[`EBC_PIN_WR_HI];
  assign fetch_indicator_out = pin_q[`EBC_PIN_FETCH];

  // Address/data bus, same one-cycle lag as the strobes
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ad_out      <= 16'h0000;
      ad_oe_n_out <= 1'b1;
      addr_hi_out <= 4'h0;
    end else begin
      addr_hi_out <= cyc_addr[19:16];
      if (state == ebc_pkg::st_addr) begin
        ad_out      <= cyc_addr[15:0];
        ad_oe_n_out <= 1'b0;
      end else if ((in_data || state == ebc_pkg::st_end) && cyc_write) begin
        ad_oe_n_out <= 1'b0;
        if (cyc_16 && cyc_word) begin
          ad_out <= wdata;
        end else if (second) begin
          ad_out <= {wdata[15:8], wdata[15:8]};
        end else begin
          ad_out <= {wdata[7:0], wdata[7:0]};
        end
      end else begin
        ad_oe_n_out <= 1'b1;
      end
    end
  end

  // Bus sharing outputs
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      bus_hold_ack_out    <= 1'b0;
      bus_pending_req_out <= 1'b0;
    end else begin
      bus_hold_ack_out    <= (state == ebc_pkg::st_hold);
      bus_pending_req_out <= cpu_req_in && !cpu_done_out &&
                             !is_internal(cpu_addr_in, strap_lat) &&
                             (state == ebc_pkg::st_hold || (state == ebc_pkg::st_idle && hold_in));
    end
  end

  // Non-maskable interrupt edge
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      nmi_prev       <= 1'b0;
      nmi_take_out   <= 1'b0;
      nmi_vector_out <= 16'h0000;
    end else begin
      nmi_prev     <= nmi_in;
      nmi_take_out <= nmi_in && !nmi_prev;
      if (nmi_in && !nmi_prev) begin
        nmi_vector_out <= `EBC_NMI_VECTOR;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ext_access_latched_out <= 1'b0;
    end else begin
      ext_access_latched_out <= strap_lat;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_clk_half: assert property (clk_div |=> !clk_div ##1 clk_div)
    else $error("clock divider not toggling");
  chk_width_dyn: assert property (acc_ext && dyn_width |=>
    cyc_16 == $past(bus_width_in))
    else $error("dynamic width not taken from pin");
  chk_width_fixed: assert property (acc_ext && !dyn_width |=>
    cyc_16 == $past(chip_config_reg_in[`EBC_CFG_WIDTH_BIT]))
    else $error("fixed width wrong");
  chk_nmi_edge: assert property (nmi_in && !nmi_prev |=>
    nmi_take_out && nmi_vector_out == `EBC_NMI_VECTOR)
    else $error("nmi edge not taken");
  chk_int_quiet: assert property (acc_int |=>
    state == ebc_pkg::st_idle && cpu_int_sel_out && cpu_done_out)
    else $error("internal access left idle");
  chk_strap_steady: assert property ($stable(strap_lat))
    else $error("access select changed after reset");
  chk_hold_release: assert property (state == ebc_pkg::st_hold |=>
    bus_hold_ack_out && ad_oe_n_out)
    else $error("hold without release");
  chk_hold_entry: assert property (state == ebc_pkg::st_hold &&
    $past(state) != ebc_pkg::st_hold |-> $past(state) == ebc_pkg::st_idle)
    else $error("hold entered mid cycle");
  chk_read_ext: assert property (port_func_en_in[`EBC_PIN_RD] ##1
    !read_n_out |-> $past(in_data) && !$past(cyc_write))
    else $error("read strobe outside external read");
  chk_ready_go: assert property (state == ebc_pkg::st_check && ready_in |=>
    state == ebc_pkg::st_end)
    else $error("ready high did not end wait");
  chk_wait_cap: assert property (state == ebc_pkg::st_check &&
    wait_cnt == wait_max |=> state == ebc_pkg::st_end)
    else $error("wait states exceed maximum");

  cov_hold: cover property (state == ebc_pkg::st_idle && hold_in ##1 state == ebc_pkg::st_hold);
  cov_wait: cover property (state == ebc_pkg::st_check && !ready_in ##1 state == ebc_pkg::st_check);
  cov_split: cover property (state == ebc_pkg::st_end && cont_second);
  cov_nmi: cover property (nmi_take_out);
endmodule
`default_nettype wire

// ===== tb/ebc_mem_model.sv
// Behavioural external memory answering the bus controller
`default_nettype none
module ebc_mem_model (
  // Clock
  input  wire logic        clk_in,
  // Bus pins from the device
  input  wire logic [15:0] ad_in,
  input  wire logic        ad_oe_n_in,
  input  wire logic        read_n_in,
  input  wire logic        write_n_in,
  // Test controls
  input  wire logic        wide_in,
  input  wire logic [2:0]  waits_in,
  // Answers to the device, and captured write data for the bench
  output logic [15:0]      data_out,
  output logic             ready_out,
  output logic [15:0]      wr_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [3:0]  cnt = 4'h0;
  logic [7:0]  lo;
  logic [7:0]  hi;
  initial wr_data_out = 16'h0000;
  // Byte at address a holds a[7:0] ^ 3c
  assign lo = {addr[7:1], wide_in ? 1'b0 : addr[0]} ^ 8'h3c;
  assign hi = {addr[7:1], 1'b1} ^ 8'h3c;
  // Released bus keeps changing so a stale sample cannot pass
  assign data_out = read_n_in ? ~last : (wide_in ? {hi, lo} : {lo, lo});
  // Ready low for the first waits_in strobe cycles
  assign ready_out = cnt >= {1'b0, waits_in};
  always @(posedge clk_in) begin
    last <= data_out;
    cnt <= (read_n_in && write_n_in) ? 4'h0 : cnt + 4'h1;
    if (!ad_oe_n_in && read_n_in && write_n_in) begin
      addr <= ad_in;
    end
    if (!write_n_in) begin
      wr_data_out <= ad_in;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the external bus controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, rst_b_in = 0, cpu_req_in = 0, cpu_write_in = 0;
  logic        cpu_fetch_in = 0, cpu_word_in = 0, bus_width_in = 0, nmi_in = 0;
  logic        ext_access_select_in = 0, hold_in = 0, wide = 1, isel;
  logic [23:0] cpu_addr_in = 24'h000000;
  logic [15:0] cpu_wdata_in = 16'h0000, rd, cpu_rdata_out, ad_out, nmi_vector_out;
  logic [7:0]  cfg = 8'h02, cfg2 = 8'h00;
  logic [5:0]  port_func_en_in = 6'h3f, port_data_in = 6'h00;
  logic [3:0]  addr_hi_out;
  logic [2:0]  waits = 3'h0;
  logic        cpu_done_out, cpu_int_sel_out, ad_oe_n_out, clock_out, addr_strobe_out;
  logic        read_n_out, write_low_n_out, write_high_n_out, fetch_indicator_out;
  logic        bus_hold_ack_out, bus_pending_req_out, nmi_take_out, ext_access_latched_out;
  wire  [15:0] ad_in, wr_data;
  wire         ready_in;
  int          n, rd_c, wl_c, wh_c, stb_c, fe_c, fe_bad, k, fail_count = 0, checked = 0;

  ebc_bus_ctrl ebc_bus_ctrl_fetch_indicator (.clk_in, .rst_b_in, .cpu_req_in, .cpu_write_in,
    .cpu_fetch_in, .cpu_word_in, .cpu_addr_in, .cpu_wdata_in, .cpu_rdata_out,
    .cpu_done_out, .cpu_int_sel_out, .chip_config_reg_in(cfg),
    .chip_config_reg_second_in(cfg2), .port_func_en_in, .port_data_in, .bus_width_in,
    .ready_in, .nmi_in, .ext_access_select_in, .hold_in, .ad_in, .ad_out, .ad_oe_n_out,
    .addr_hi_out, .clock_out, .addr_strobe_out, .read_n_out, .write_low_n_out,
    .write_high_n_out, .fetch_indicator_out, .bus_hold_ack_out, .bus_pending_req_out,
    .nmi_take_out, .nmi_vector_out, .ext_access_latched_out);
  ebc_mem_model ebc_mem_model_fetch_indicator (.clk_in, .ad_in(ad_out), .ad_oe_n_in(ad_oe_n_out),
    .read_n_in(read_n_out), .write_n_in(write_low_n_out), .wide_in(wide),
    .waits_in(waits), .data_out(ad_in), .ready_out(ready_in), .wr_data_out(wr_data));

  always #20 clk_in = ~clk_in;

  task automatic summarize();
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo();
    $display("[ERR] %0t wait ran out", $time);
    fail_count++;
    summarize();
  endtask
  task automatic chkv(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    checked++;
    if (g != e) begin
      fail_count++;
      $display("[ERR] %0t cycles %0d expected %0d", $time, g, e);
    end
  endtask
  function automatic logic [7:0] bv(input logic [15:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset(input logic sel);
    step();
    rst_b_in = 0;
    ext_access_select_in = sel;
    repeat (20) @(posedge clk_in);
    #1;
    rst_b_in = 1;
    ext_access_select_in = ~sel;
    repeat (2) step();
    chkb(ext_access_latched_out, sel);
  endtask
  task automatic go(input logic w, f, wd, input logic [23:0] a, input logic [15:0] d);
    cpu_write_in = w;
    cpu_fetch_in = f;
    cpu_word_in = wd;
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_req_in = 1;
  endtask
  // Counts pin activity until done; drops the request in the done cycle
  task automatic fin();
    logic dn;
    dn = 0;
    n = 0;
    {rd_c, wl_c, wh_c, stb_c, fe_c, fe_bad} = '0;
    while (!dn && n < 40) begin
      step();
      n++;
      rd_c += (read_n_out === 1'b0);
      wl_c += (write_low_n_out === 1'b0);
      wh_c += (write_high_n_out === 1'b0);
      stb_c += (addr_strobe_out === ~cfg[4]);
      fe_c += (fetch_indicator_out === 1'b1);
      fe_bad += (read_n_out === 1'b0 && fetch_indicator_out !== cpu_fetch_in);
      dn = (cpu_done_out === 1'b1);
    end
    if (!dn) tmo();
    isel = cpu_int_sel_out;
    rd = cpu_rdata_out;
    cpu_req_in = 0;
  endtask
  task automatic acc(input logic w, f, wd, input logic [23:0] a, input logic [15:0] d);
    go(w, f, wd, a, d);
    fin();
  endtask

  task automatic s_clk();
    logic p;
    p = clock_out;
    repeat (4) begin
      step();
      chkb(clock_out, ~p);
      p = clock_out;
    end
    port_func_en_in = 6'h3a;
    port_data_in = 6'h01;
    repeat (2) step();
    chkb(clock_out, 1);
    chkb(read_n_out, 0);
    step();
    chkb(clock_out, 1);
    port_func_en_in = 6'h3f;
    port_data_in = 6'h00;
  endtask
  task automatic s_int();
    acc(0, 1, 1, 24'hff2080, 0);
    chkn(n, 1);
    chkb(isel, 1);
    chkn(stb_c + rd_c, 0);
    chkn(fe_c, 0);
  endtask
  task automatic s_ext();
    acc(0, 1, 1, 24'hff2080, 0);
    chkb(isel, 0);
    chkv({12'h000, addr_hi_out}, 16'h000f);
    chkv(rd, {bv(16'h2081), bv(16'h2080)});
    chkb(fe_c > 0 && rd_c > 0, 1);
    chkn(fe_bad, 0);
    chkb(stb_c > 0, 1);
  endtask
  task automatic s_width();
    for (int i = 0; i < 4; i++) begin
      cfg = (i == 1) ? 8'h00 : 8'h02;
      cfg2 = (i == 0) ? 8'h00 : 8'h04;
      bus_width_in = (i == 3);
      wide = (i == 0 || i == 3);
      acc(0, 0, 1, 24'h001234, 0);
      chkn(n, wide ? 6 : 10);
      chkv(rd, {bv(16'h1235), bv(16'h1234)});
    end
    cfg2 = 8'h00;
    wide = 1;
  endtask
  task automatic s_wait();
    cfg = 8'he2;
    waits = 3'h2;
    acc(0, 0, 1, 24'h000200, 0);
    chkn(n, 8);
    chkv(rd, {bv(16'h0201), bv(16'h0200)});
    cfg = 8'h62;
    waits = 3'h5;
    acc(0, 0, 1, 24'h000200, 0);
    chkn(n, 9);
    waits = 3'h0;
  endtask
  task automatic s_strobe();
    cfg = 8'h12;
    acc(0, 0, 1, 24'h000300, 0);
    chkb(stb_c > 0, 1);
    chkb(addr_strobe_out, 1);
    cfg = 8'h02;
  endtask
  task automatic s_write();
    acc(1, 0, 1, 24'h000100, 16'ha55a);
    chkv(wr_data, 16'ha55a);
    chkb(wl_c > 0 && wh_c > 0, 1);
    chkn(rd_c, 0);
    acc(1, 0, 0, 24'h000101, 16'h00c3);
    chkb(wl_c > 0, 1);
    cfg = 8'h0e;
    acc(1, 0, 0, 24'h000101, 16'h00c3);
    chkn(wl_c, 0);
    chkb(wh_c > 0, 1);
    cfg = 8'h02;
    acc(0, 0, 0, 24'h000101, 0);
    chkv(rd, {8'h00, bv(16'h0101)});
    chkb(wh_c > 0, 1);
    acc(0, 0, 0, 24'h000100, 0);
    chkn(wh_c, 0);
  endtask
  task automatic s_hold();
    go(0, 0, 1, 24'h000400, 0);
    // First edge is refused while the last done still stands
    repeat (2) step();
    hold_in = 1;
    fin();
    chkn(n, 4);
    chkb(bus_hold_ack_out, 0);
    k = 0;
    while (bus_hold_ack_out !== 1'b1 && k < 10) begin
      step();
      k++;
    end
    if (bus_hold_ack_out !== 1'b1) tmo();
    chkb(ad_oe_n_out, 1);
    go(0, 0, 1, 24'h000402, 0);
    repeat (4) begin
      step();
      chkb(cpu_done_out, 0);
    end
    chkb(bus_pending_req_out, 1);
    hold_in = 0;
    fin();
    chkb(bus_hold_ack_out, 0);
    chkb(bus_pending_req_out, 0);
    chkv(rd, {bv(16'h0403), bv(16'h0402)});
  endtask
  task automatic s_nmi();
    chkv(nmi_vector_out, 16'h0000);
    nmi_in = 1;
    k = 0;
    while (nmi_take_out !== 1'b1 && k < 4) begin
      step();
      k++;
    end
    if (nmi_take_out !== 1'b1) tmo();
    chkv(nmi_vector_out, 16'h203e);
    repeat (3) begin
      step();
      chkb(nmi_take_out, 0);
    end
    nmi_in = 0;
  endtask

  initial begin
    do_reset(1'b1);
    s_clk();
    s_int();
    do_reset(1'b0);
    s_ext();
    s_width();
    s_wait();
    s_strobe();
    s_write();
    s_hold();
    s_nmi();
    summarize();
  end
endmodule
`default_nettype wire
